// ### rtl/flow_measurement_error_checker.sv
// Plausibility and error checking of flow measurement cycles
//
// Function
// RQ1: Reject speed of sound outside bounds.
// RQ2: Invalid measurement keeps last valid result.
// RQ3: Flag transit sum jump from 8-mean.
// RQ4: Zero limit disables; config bits otherwise.
// RQ5: Flag fast oscillator drift from nominal.
// RQ6: Flag bubbles on amplitude or width mismatch.
// RQ7: Flag no-water after consecutive low amplitudes.
// RQ8: Software programs low amplitude count.
// RQ9: Flow above twice maximum exceeds limit.
// RQ10: Bit 16 clear zeroes flow, flags error.
// RQ11: Bit 27 enables speed of sound check.
// RQ12: Bits 21/22 steer pulse interface errors.
// RQ13: Boot copies image into hardware enable.
// RQ14: Mismatching stored checksum raises checksum error.
// RQ15: Maximum speed uses 8 fraction bits.
// RQ16: Temperature/minimum speed split across bytes.
// RQ17: Software sets transit sum limit.
// RQ18: Software sets oscillator deviation limit.
// RQ19: Amplitude limit 0x00200000 means 32 mV.
// RQ20: Width limit 0x0000000C means 0.094.
// RQ21: Software keeps maximum flow nonzero.
// RQ22: Each error has its own status flag.
module flow_measurement_error_checker
   import flow_check_pkg::*;
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   // Measurement cycle
   input  wire logic              meas_valid,
   input  wire meas_t             meas,
   input  wire logic [31:0]       hw_error_flag_reg,
   input  wire logic              boot_load,
   input  wire logic              cs_valid,
   input  wire cs_t               cs_calc,
   // Results
   output logic                   meas_done,
   output err_flags_t             err_flags,
   output logic      [31:0]       flow_out,
   output logic                   pulse_if_error,
   output logic      [31:0]       hw_error_active,
   output logic      [31:0]       hw_error_enable,
   output logic      [23:0]       max_speed_temp
);

   function automatic logic [SLOT_W:0] slot_of(input logic [ADDR_W-1:0] a);
      logic [SLOT_W:0] r;
      r = '0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (a[ADDR_W-1:2] == SLOT_IDX[i]) begin
            r = {1'b1, i[SLOT_W-1:0]};
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   logic [31:0]     mem [NUM_SLOTS];
   logic            waitrequest_reg;
   logic [31:0]     readdata_reg;
   logic [SLOT_W:0] slot;
   logic [31:0]     rd_value;
   err_flags_t      err_reg;
   logic            cs_err_reg;
   logic [31:0]     flow_reg;
   logic            done_reg;
   logic            pi_err_reg;
   logic [31:0]     hw_en_reg;
   logic [31:0]     hw_act_reg;
   logic [23:0]     temp_reg;
   logic [31:0]     hist [TSUM_HISTORY];
   logic [2:0]      hist_ptr_reg;
   logic [3:0]      hist_fill_reg;
   logic [34:0]     hist_sum_reg;
   logic [31:0]     low_cnt_reg;
   logic [31:0]     low_cnt_next;

   wire logic [31:0] cfg = mem[S_CONFIG];
   wire logic [31:0] sos_max = mem[S_SOS_MAX];
   wire logic [31:0] sos_tmin = mem[S_SOS_TMIN];
   wire logic [31:0] max_flow = mem[S_MAX_FLOW];
   wire logic        bus_req = read | write;
   wire logic        bus_go = bus_req & ~waitrequest_reg;

   assign slot = slot_of(address);

   // Register bus: one wait cycle, then the access completes
   always_ff @(posedge clock) begin
      if (!nrst) begin
         waitrequest_reg <= 1'b1;
      end else begin
         waitrequest_reg <= ~(bus_req & waitrequest_reg);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            mem[i] <= SLOT_RESET[i];
         end
      end else if (write && bus_go && slot[SLOT_W]) begin
         for (int b = 0; b < 4; b++) begin
            if (byteenable[b]) begin
               mem[slot[SLOT_W-1:0]][8*b +: 8] <= writedata[8*b +: 8];
            end
         end
      end
   end

   always_comb begin
      rd_value = '0;
      if (slot[SLOT_W]) begin
         rd_value = mem[slot[SLOT_W-1:0]];
      end else begin
         case (address[ADDR_W-1:2])
            ERROR_STATUS_IDX:        rd_value = {24'h000000, err_flags};
            HW_ERROR_ENABLE_REG_IDX: rd_value = hw_en_reg;
            HELD_FLOW_IDX:           rd_value = flow_reg;
            default:                 rd_value = '0;
         endcase
      end
   end

   // Latched a cycle early so data stands at the completing edge
   always_ff @(posedge clock) begin
      if (!nrst) begin
         readdata_reg <= '0;
      end else if (read && waitrequest_reg) begin
         readdata_reg <= rd_value;
      end
   end

   // Speed of sound window, minimum moved from 5 to 8 fraction bits
   wire logic [31:0] sos_min = {21'h000000, sos_tmin[7:0], 3'h0}; // [RQ16]
   wire logic sos_err = cfg[SOUND_SPEED_CHECK_BIT] &&
                        (meas.sound_speed > sos_max ||
                         meas.sound_speed < sos_min); // [RQ1] [RQ11] [RQ4]

   // Transit sum against mean of the last eight
   wire logic [31:0] tsum_mean = hist_sum_reg[34:3];
   wire logic tsum_err = mem[S_TSUM_LIM] != '0 && hist_fill_reg == TSUM_FULL &&
                         absdiff(meas.transit_time_sum, tsum_mean)
                         > mem[S_TSUM_LIM]; // [RQ3] [RQ4]

   wire logic osc_err = mem[S_OSC_LIM] != '0 &&
                        absdiff(meas.osc_count, OSC_NOMINAL_COUNT)
                        > mem[S_OSC_LIM]; // [RQ5] [RQ4]

   // Both sides in the limits' own units: mV with 16, ratio with 7 fraction bits
   wire logic amp_err = mem[S_AMP_DIFF] != '0 &&
                        absdiff(meas.amp_up, meas.amp_down)
                        > mem[S_AMP_DIFF]; // [RQ6] [RQ19] [RQ4]
   wire logic pwr_err = mem[S_PW_DEV] != '0 &&
                        absdiff(meas.pwr_up, meas.pwr_down)
                        > mem[S_PW_DEV]; // [RQ6] [RQ20] [RQ4]

   wire logic amp_low = mem[S_AMP_MIN] != '0 &&
                        (meas.amp_up < mem[S_AMP_MIN] ||
                         meas.amp_down < mem[S_AMP_MIN]); // [RQ4]

   always_comb begin
      low_cnt_next = '0;
      if (amp_low) begin
         low_cnt_next = (low_cnt_reg == '1) ? low_cnt_reg : low_cnt_reg + 32'h1;
      end
   end

   wire logic nowater_err = amp_low && low_cnt_next >= mem[S_LOW_CNT]; // [RQ7]

   // Flow magnitude against twice the maximum, both with 16 fraction bits
   wire logic [31:0] flow_mag = meas.flow[31] ? 32'h0 - meas.flow : meas.flow;
   wire logic [48:0] flow_lim2 = {max_flow, 17'h00000};
   wire logic flow_over = {17'h00000, flow_mag} > flow_lim2; // [RQ9]
   wire logic flow_err = flow_over && !cfg[KEEP_FLOW_OVER_LIMIT_BIT]; // [RQ10]

   wire logic invalid = sos_err | tsum_err | amp_err | pwr_err | nowater_err;

   wire logic cs_mismatch = cs_calc.area1 != mem[S_CS1] ||
                            cs_calc.area2 != mem[S_CS1 + 4'h1] ||
                            cs_calc.user_code != mem[S_CS1 + 4'h2] ||
                            cs_calc.vendor_code != mem[S_CS1 + 4'h3];

   always_ff @(posedge clock) begin
      if (!nrst) begin
         low_cnt_reg <= '0;
      end else if (meas_valid) begin
         low_cnt_reg <= low_cnt_next; // [RQ7]
      end
   end

   // History of transit sums, kept as a running sum
   always_ff @(posedge clock) begin
      if (!nrst) begin
         hist_ptr_reg  <= '0;
         hist_fill_reg <= '0;
         hist_sum_reg  <= '0;
         for (int i = 0; i < TSUM_HISTORY; i++) begin
            hist[i] <= '0;
         end
      end else if (meas_valid) begin
         hist[hist_ptr_reg] <= meas.transit_time_sum;
         hist_ptr_reg <= hist_ptr_reg + 3'h1;
         hist_sum_reg <= hist_sum_reg + {3'h0, meas.transit_time_sum}
                         - {3'h0, hist[hist_ptr_reg]}; // [RQ3]
         if (hist_fill_reg != TSUM_FULL) begin
            hist_fill_reg <= hist_fill_reg + 4'h1;
         end
      end
   end

   // Error flags except checksum refreshed once per measurement cycle; checksum follows cs_valid
   always_ff @(posedge clock) begin
      if (!nrst) begin
         err_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= meas_valid;
         if (meas_valid) begin
            err_reg.sound_speed <= sos_err;
            err_reg.transit_sum <= tsum_err;
            err_reg.osc_cal     <= osc_err;
            err_reg.amp_bubble  <= amp_err;
            err_reg.pwr_bubble  <= pwr_err;
            err_reg.no_water    <= nowater_err;
            err_reg.flow_limit  <= flow_err; // [RQ22]
            err_reg.checksum    <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cs_err_reg <= 1'b0;
      end else if (cs_valid) begin
         cs_err_reg <= cs_mismatch; // [RQ14]
      end
   end

   // Invalid cycles leave the presented result untouched
   always_ff @(posedge clock) begin
      if (!nrst) begin
         flow_reg <= '0;
      end else if (meas_valid && !invalid) begin // [RQ2]
         flow_reg <= flow_err ? 32'h0 : meas.flow; // [RQ10]
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         pi_err_reg <= 1'b0;
      end else if (meas_valid) begin
         pi_err_reg <= !cfg[PULSE_IF_ERROR_MUTE_BIT] &&
                       (sos_err | tsum_err | osc_err | amp_err | pwr_err |
                        flow_err | cs_err_reg |
                        (cfg[PULSE_IF_NOWATER_ERROR_BIT] && nowater_err)); // [RQ12]
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         hw_en_reg <= '0;
      end else if (boot_load) begin
         hw_en_reg <= mem[S_HW_IMAGE]; // [RQ13]
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         hw_act_reg <= '0;
         temp_reg   <= '0;
      end else begin
         hw_act_reg <= hw_error_flag_reg & hw_en_reg; // [RQ13]
         temp_reg   <= sos_tmin[31:8]; // [RQ16]
      end
   end

   assign readdata        = readdata_reg;
   assign waitrequest     = waitrequest_reg;
   assign meas_done       = done_reg;
   assign err_flags       = '{checksum: cs_err_reg, flow_limit: err_reg.flow_limit,
                              no_water: err_reg.no_water, pwr_bubble: err_reg.pwr_bubble,
                              amp_bubble: err_reg.amp_bubble, osc_cal: err_reg.osc_cal,
                              transit_sum: err_reg.transit_sum,
                              sound_speed: err_reg.sound_speed};
   assign flow_out        = flow_reg;
   assign pulse_if_error  = pi_err_reg;
   assign hw_error_active = hw_act_reg;
   assign hw_error_enable = hw_en_reg;
   assign max_speed_temp  = temp_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   property p_sos_high;
      meas_valid && cfg[SOUND_SPEED_CHECK_BIT] && meas.sound_speed > sos_max
      |=> err_flags.sound_speed && meas_done;
   endproperty
   a_sos_high: assert property (p_sos_high) // [RQ1]
      else $error("speed above maximum not flagged");

   property p_sos_off;
      meas_valid && !cfg[SOUND_SPEED_CHECK_BIT] |=> !err_flags.sound_speed;
   endproperty
   a_sos_off: assert property (p_sos_off) // [RQ11]
      else $error("speed check active while disabled");

   property p_hold;
      meas_valid && invalid |=> flow_out == $past(flow_out);
   endproperty
   a_hold: assert property (p_hold) // [RQ2]
      else $error("invalid measurement changed result");

   property p_tsum_off;
      meas_valid && mem[S_TSUM_LIM] == '0 |=> !err_flags.transit_sum;
   endproperty
   a_tsum_off: assert property (p_tsum_off) // [RQ4]
      else $error("zero transit limit still flags");

   property p_tsum_mean;
      hist_fill_reg == TSUM_FULL && meas_valid && mem[S_TSUM_LIM] != '0 &&
      meas.transit_time_sum > tsum_mean + mem[S_TSUM_LIM]
      |=> err_flags.transit_sum;
   endproperty
   a_tsum_mean: assert property (p_tsum_mean) // [RQ3]
      else $error("transit sum jump not flagged");

   property p_osc;
      meas_valid && mem[S_OSC_LIM] != '0 &&
      meas.osc_count > OSC_NOMINAL_COUNT + mem[S_OSC_LIM]
      |=> err_flags.osc_cal;
   endproperty
   a_osc: assert property (p_osc) // [RQ5]
      else $error("oscillator drift not flagged");

   property p_flow_zero;
      meas_valid && !invalid && flow_over && !cfg[KEEP_FLOW_OVER_LIMIT_BIT]
      |=> flow_out == 32'h0 && err_flags.flow_limit;
   endproperty
   a_flow_zero: assert property (p_flow_zero) // [RQ10]
      else $error("flow over limit not zeroed");

   property p_flow_keep;
      meas_valid && !invalid && cfg[KEEP_FLOW_OVER_LIMIT_BIT]
      |=> flow_out == $past(meas.flow) && !err_flags.flow_limit;
   endproperty
   a_flow_keep: assert property (p_flow_keep) // [RQ10]
      else $error("flow altered while limit off");

   property p_mute;
      meas_valid && cfg[PULSE_IF_ERROR_MUTE_BIT] |=> !pulse_if_error;
   endproperty
   a_mute: assert property (p_mute) // [RQ12]
      else $error("pulse interface error while muted");

   property p_boot;
      boot_load |=> hw_error_enable == $past(mem[S_HW_IMAGE]);
   endproperty
   a_boot: assert property (p_boot) // [RQ13]
      else $error("boot did not load hardware enable");

   property p_cs;
      cs_valid && cs_mismatch |=> err_flags.checksum;
   endproperty
   a_cs: assert property (p_cs) // [RQ14]
      else $error("checksum mismatch not flagged");

   property p_bubble;
      meas_valid && mem[S_AMP_DIFF] != '0 &&
      meas.amp_up > meas.amp_down + mem[S_AMP_DIFF]
      |=> err_flags.amp_bubble && flow_out == $past(flow_out);
   endproperty
   a_bubble: assert property (p_bubble) // [RQ6]
      else $error("amplitude bubble not flagged");

   property p_nowater;
      meas_valid && !amp_low |=> low_cnt_reg == '0 && !err_flags.no_water;
   endproperty
   a_nowater: assert property (p_nowater) // [RQ7]
      else $error("low amplitude run not restarted");

   property p_bus;
      bus_req && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_bus: assert property (p_bus)
      else $error("bus access not answered in one wait cycle");

endmodule

// ### include/flow_check_pkg.sv
// Constants and types of the flow measurement error checker
package flow_check_pkg;

   localparam int ADDR_W = 10;
   localparam int SLOT_W = 4;
   localparam int NUM_SLOTS = 15;

   // Register indices; byte address is four times the index
   localparam logic [7:0] SOUND_SPEED_MAX_IDX       = 8'h4a;
   localparam logic [7:0] SOUND_SPEED_TEMP_MIN_IDX  = 8'h4d;
   localparam logic [7:0] LOW_AMPLITUDE_COUNT_IDX   = 8'h4e;
   localparam logic [7:0] TRANSIT_SUM_VAR_LIMIT_IDX = 8'h51;
   localparam logic [7:0] OSC_CAL_DEV_LIMIT_IDX     = 8'h52;
   localparam logic [7:0] AMPLITUDE_DIFF_LIMIT_IDX  = 8'h54;
   localparam logic [7:0] AMPLITUDE_MIN_LIMIT_IDX   = 8'h55;
   localparam logic [7:0] PULSE_WIDTH_DEV_LIMIT_IDX = 8'h57;
   localparam logic [7:0] MAX_FLOW_LIMIT_IDX        = 8'h5c;
   localparam logic [7:0] HW_ERROR_ENABLE_IMAGE_IDX = 8'h70;
   localparam logic [7:0] PARAM_AREA1_CHECKSUM_IDX  = 8'h7c;
   localparam logic [7:0] PARAM_AREA2_CHECKSUM_IDX  = 8'h7d;
   localparam logic [7:0] USER_CODE_CHECKSUM_IDX    = 8'h7e;
   localparam logic [7:0] VENDOR_CODE_CHECKSUM_IDX  = 8'h7f;
   localparam logic [7:0] FIRMWARE_CONFIG_WORD_IDX  = 8'h80;
   localparam logic [7:0] ERROR_STATUS_IDX          = 8'h81;
   localparam logic [7:0] HW_ERROR_ENABLE_REG_IDX   = 8'h82;
   localparam logic [7:0] HELD_FLOW_IDX             = 8'h83;

   // Storage slots, in the order of the index table
   localparam logic [SLOT_W-1:0] S_SOS_MAX  = 4'h0;
   localparam logic [SLOT_W-1:0] S_SOS_TMIN = 4'h1;
   localparam logic [SLOT_W-1:0] S_LOW_CNT  = 4'h2;
   localparam logic [SLOT_W-1:0] S_TSUM_LIM = 4'h3;
   localparam logic [SLOT_W-1:0] S_OSC_LIM  = 4'h4;
   localparam logic [SLOT_W-1:0] S_AMP_DIFF = 4'h5;
   localparam logic [SLOT_W-1:0] S_AMP_MIN  = 4'h6;
   localparam logic [SLOT_W-1:0] S_PW_DEV   = 4'h7;
   localparam logic [SLOT_W-1:0] S_MAX_FLOW = 4'h8;
   localparam logic [SLOT_W-1:0] S_HW_IMAGE = 4'h9;
   localparam logic [SLOT_W-1:0] S_CS1      = 4'ha;
   localparam logic [SLOT_W-1:0] S_CONFIG   = 4'he;

   localparam logic [7:0] SLOT_IDX [NUM_SLOTS] = '{
      SOUND_SPEED_MAX_IDX, SOUND_SPEED_TEMP_MIN_IDX, LOW_AMPLITUDE_COUNT_IDX,
      TRANSIT_SUM_VAR_LIMIT_IDX, OSC_CAL_DEV_LIMIT_IDX, AMPLITUDE_DIFF_LIMIT_IDX,
      AMPLITUDE_MIN_LIMIT_IDX, PULSE_WIDTH_DEV_LIMIT_IDX, MAX_FLOW_LIMIT_IDX,
      HW_ERROR_ENABLE_IMAGE_IDX, PARAM_AREA1_CHECKSUM_IDX, PARAM_AREA2_CHECKSUM_IDX,
      USER_CODE_CHECKSUM_IDX, VENDOR_CODE_CHECKSUM_IDX, FIRMWARE_CONFIG_WORD_IDX};

   // Values after reset (water defaults where they exist)
   localparam logic [31:0] SLOT_RESET [NUM_SLOTS] = '{
      32'h00061400, 32'h004a002b, 32'h00000020, 32'h0001ffff, 32'h0009c400,
      32'h00200000, 32'h00000000, 32'h0000000c, 32'h00000000, 32'h00000000,
      32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};

   // Bits of the firmware configuration word
   localparam int KEEP_FLOW_OVER_LIMIT_BIT   = 16;
   localparam int PULSE_IF_ERROR_MUTE_BIT    = 21;
   localparam int PULSE_IF_NOWATER_ERROR_BIT = 22;
   localparam int SOUND_SPEED_CHECK_BIT      = 27;

   // Nominal fast oscillator count over four slow periods at 4 MHz
   localparam logic [31:0] OSC_NOMINAL_COUNT = 32'h01e84800;
   localparam int          TSUM_HISTORY      = 8;
   localparam logic [3:0]  TSUM_FULL         = 4'h8;

   typedef struct packed {
      logic [31:0] sound_speed;     // m/s, 8 fraction bits
      logic [31:0] transit_time_sum;
      logic [31:0] osc_count;       // fast_oscillator ticks over 4 slow periods
      logic [31:0] amp_up;          // mV, 16 fraction bits
      logic [31:0] amp_down;
      logic [31:0] pwr_up;          // 7 fraction bits
      logic [31:0] pwr_down;
      logic [31:0] flow;            // signed l/h, 16 fraction bits
   } meas_t;

   typedef struct packed {
      logic [31:0] area1;
      logic [31:0] area2;
      logic [31:0] user_code;
      logic [31:0] vendor_code;
   } cs_t;

   typedef struct packed {
      logic checksum;
      logic flow_limit;
      logic no_water;
      logic pwr_bubble;
      logic amp_bubble;
      logic osc_cal;
      logic transit_sum;
      logic sound_speed;
   } err_flags_t;

endpackage

// ### verification/tb_top.sv
// Self-checking testbench of the flow measurement error checker
module tb_top
   import flow_check_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [31:0]       writedata = '0;
   logic [31:0]       readdata;
   logic              waitrequest;
   logic              meas_valid = 1'b0;
   meas_t             meas = '0;
   logic [31:0]       hw_flags = '0;
   logic              boot_load = 1'b0;
   logic              cs_valid = 1'b0;
   cs_t               cs_calc = '0;
   logic              meas_done;
   err_flags_t        err_flags;
   logic [31:0]       flow_out;
   logic              pulse_if_error;
   logic [31:0]       hw_error_active;
   logic [31:0]       hw_error_enable;
   logic [23:0]       max_speed_temp;
   int                err_count = 0;
   int                num_checks = 0;
   // Bench copy of the configuration and of the running state
   logic [31:0]       cfg = '0;
   logic [31:0]       lim [9];
   logic [31:0]       csv [4];
   logic [31:0]       last_flow = '0;
   logic              cs_err = 1'b0;
   longint            hist [$];
   int                run = 0;

   always #12.5 clock = ~clock;

   flow_measurement_error_checker dut (.clock(clock), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
      .readdata(readdata), .waitrequest(waitrequest), .meas_valid(meas_valid),
      .meas(meas), .hw_error_flag_reg(hw_flags), .boot_load(boot_load),
      .cs_valid(cs_valid), .cs_calc(cs_calc), .meas_done(meas_done),
      .err_flags(err_flags), .flow_out(flow_out), .pulse_if_error(pulse_if_error),
      .hw_error_active(hw_error_active), .hw_error_enable(hw_error_enable),
      .max_speed_temp(max_speed_temp));

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_flags(input err_flags_t e, input err_flags_t g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value err_flags expected %b seen %b", e, g);
      end
   endtask

   // Request held until waitrequest is seen low, then released
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      address <= {idx, 2'b00};
      writedata <= d;
      write <= wr;
      read <= !wr;
      // Sampled at the rising edge itself: the completing edge is the one with waitrequest low
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      if (waitrequest !== 1'b0) begin
         err_count++;
         conclude();
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, idx, '0, q);
      chk_word("readdata", e, q);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
      rd_chk(idx, d);
   endtask

   function automatic longint ab(input longint v);
      return v < 0 ? -v : v;
   endfunction

   task automatic meas_run(input meas_t m);
      err_flags_t e;
      longint     mean;
      logic       pi;
      mean = 0;
      foreach (hist[i]) mean += hist[i];
      mean = mean / 8;
      e.sound_speed = cfg[SOUND_SPEED_CHECK_BIT] && (m.sound_speed > lim[0] ||
                      m.sound_speed < {lim[1][7:0], 3'b000});
      e.transit_sum = lim[3] != 0 && hist.size() == 8 &&
                      ab(longint'(m.transit_time_sum) - mean) > longint'(lim[3]);
      e.osc_cal = lim[4] != 0 &&
                  ab(longint'(m.osc_count) - longint'(OSC_NOMINAL_COUNT)) > longint'(lim[4]);
      e.amp_bubble = lim[5] != 0 &&
                     ab(longint'(m.amp_up) - longint'(m.amp_down)) > longint'(lim[5]);
      e.pwr_bubble = lim[7] != 0 &&
                     ab(longint'(m.pwr_up) - longint'(m.pwr_down)) > longint'(lim[7]);
      run = (lim[6] != 0 && (m.amp_up < lim[6] || m.amp_down < lim[6])) ? run + 1 : 0;
      e.no_water = run >= lim[2];
      e.flow_limit = !cfg[KEEP_FLOW_OVER_LIMIT_BIT] &&
                     ab(longint'($signed(m.flow))) > longint'(lim[8]) * 131072;
      e.checksum = cs_err;
      hist.push_back(longint'(m.transit_time_sum));
      if (hist.size() > 8)
         void'(hist.pop_front());
      if (!(e.sound_speed | e.transit_sum | e.amp_bubble | e.pwr_bubble | e.no_water))
         last_flow = e.flow_limit ? '0 : m.flow;
      pi = !cfg[PULSE_IF_ERROR_MUTE_BIT] && (|e[7:6] || |e[4:0] ||
           (e.no_water && cfg[PULSE_IF_NOWATER_ERROR_BIT]));
      meas <= m;
      meas_valid <= 1'b1;
      @(posedge clock);
      meas_valid <= 1'b0;
      @(negedge clock);
      chk_word("meas_done", 32'h1, meas_done);
      chk_flags(e, err_flags);
      chk_word("flow_out", last_flow, flow_out);
      chk_word("pulse_if_error", pi, pulse_if_error);
      @(posedge clock);
   endtask

   // Index 4 keeps all four computed sums equal to the stored ones
   task automatic cs_run(input int i);
      logic [127:0] c;
      c = {csv[0], csv[1], csv[2], csv[3]};
      if (i < 4)
         c[127-32*i -: 32] = ~c[127-32*i -: 32];
      cs_calc <= c;
      cs_valid <= 1'b1;
      @(posedge clock);
      cs_valid <= 1'b0;
      @(negedge clock);
      cs_err = i < 4;
      chk_word("checksum flag", cs_err, err_flags.checksum);
      @(posedge clock);
   endtask

   initial begin
      logic [31:0] q;
      logic [31:0] img;
      meas_t       m;
      void'($urandom(32'h5b404a17));
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < NUM_SLOTS; i++) rd_chk(SLOT_IDX[i], SLOT_RESET[i]);
      rd_chk(8'h10, 32'h0);
      chk_word("max_speed_temp", 32'h004a00, max_speed_temp);
      $display("test reset done");
      lim = '{32'h61400, 32'h4a002b, 32'h3, 32'h40, 32'h64, 32'h20, 32'h100, 32'hc, 32'ha};
      for (int i = 0; i < 9; i++) wr(SLOT_IDX[i], lim[i]);
      bus(1'b1, ERROR_STATUS_IDX, 32'hff, q);
      rd_chk(ERROR_STATUS_IDX, 32'h0);
      img = $urandom();
      wr(HW_ERROR_ENABLE_IMAGE_IDX, img);
      hw_flags <= $urandom();
      boot_load <= 1'b1;
      @(posedge clock);
      boot_load <= 1'b0;
      @(posedge clock);
      @(negedge clock);
      chk_word("hw_error_enable", img, hw_error_enable);
      chk_word("hw_error_active", img & hw_flags, hw_error_active);
      @(posedge clock);
      rd_chk(HW_ERROR_ENABLE_REG_IDX, img);
      $display("test boot done");
      for (int i = 0; i < 4; i++) begin
         csv[i] = $urandom();
         wr(PARAM_AREA1_CHECKSUM_IDX + 8'(i), csv[i]);
      end
      for (int i = 0; i < 8; i++) cs_run(i[0] ? i / 2 : 4);
      $display("test checksum done");
      for (int k = 0; k < 17; k++) begin
         cfg = '0;
         cfg[SOUND_SPEED_CHECK_BIT] = k[0];
         cfg[PULSE_IF_ERROR_MUTE_BIT] = k[1];
         cfg[PULSE_IF_NOWATER_ERROR_BIT] = k[2];
         cfg[KEEP_FLOW_OVER_LIMIT_BIT] = k[3];
         wr(FIRMWARE_CONFIG_WORD_IDX, cfg);
         if (k == 4)
            cs_run(4);
         if (k == 16)
            for (int i = 3; i < 8; i++) begin
               lim[i] = '0;
               wr(SLOT_IDX[i], 32'h0);
            end
         for (int j = 0; j < 12; j++) begin
            m.sound_speed = ($urandom_range(0, 1) ? lim[0] : {21'h0, lim[1][7:0], 3'b000})
                            + $urandom_range(0, 6) - 3;
            m.transit_time_sum = 32'h10000 + 8 * $urandom_range(0, 3)
                                 + ($urandom_range(0, 7) == 0 ? 32'h400 : 32'h0);
            m.osc_count = OSC_NOMINAL_COUNT + $urandom_range(0, 202) - 101;
            m.amp_up = ($urandom_range(0, 2) == 0) ? 32'hff : 32'h100 + $urandom_range(0, 40);
            m.amp_down = m.amp_up + $urandom_range(0, 68) - 34;
            m.pwr_up = 32'h80;
            m.pwr_down = 32'h80 + $urandom_range(0, 26) - 13;
            m.flow = $urandom_range(0, 2625440) - 1312720;
            if (j == 0)
               m.flow = 32'd1310720 + k[0];
            if (j == 1)
               m.osc_count = OSC_NOMINAL_COUNT + 32'd100 + k[1];
            meas_run(m);
         end
      end
      $display("test measurement done");
      conclude();
   end
endmodule
